/* hdl/mlda_aligner.sv */
// Four-lane deskew aligner with Wishbone register slave
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
`include "mlda_defines.svh"

module mlda_aligner
    import mlda_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire mlda_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] rx_lane_clk,
    input wire mlda_word_t [3:0] rx_lane_in,
    input wire logic align_en,
    input wire logic align_resync,
    output mlda_word_t [3:0] lane_out,
    output logic [3:0] lane_out_valid,
    output logic aligned_01,
    output logic aligned_23,
    output logic status_irq
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    // Software registers
    logic [7:0] clk_sel_r;
    logic [7:0] lane_en_r;
    logic [7:0] mask_lo_r;
    logic [7:0] word_a_lo_r;
    logic [7:0] word_b_lo_r;
    logic [7:0] high_bits_r;
    logic [7:0] irq_en_r;
    logic [7:0] group_mode_r;
    logic [7:0] frame_mode_r;
    logic [7:0] irq_lat_r;
    logic [7:0] irq_lat_nxt;
    logic [7:0] status_w;
    logic [7:0] rd_byte;
    logic ack_r;
    logic bus_fire;
    logic bus_hit;
    logic [7:0] bus_idx;

    // Aligner reset, asserted by either reset, released on the clock
    logic aln_async_b;
    logic [1:0] aln_rst_sync_r;
    logic aln_rst_b;

    // Per-lane and per-group signals
    logic [9:0] word_a;
    logic [9:0] word_b;
    logic [9:0] cmp_mask;
    logic [3:0] in_rise;
    logic [3:0] out_edge;
    logic [3:0] head_mark;
    logic [3:0] head_valid;
    logic [3:0] overflow;
    logic [3:0] stall;
    logic [3:0] participate;
    logic [3:0] grp_mem [2];
    logic [1:0] all_mark;
    logic [1:0] grp_lost;
    logic [1:0] grp_locked;
    logic [3:0] lane_in_grp;
    logic [3:0] lane_grp_idx;

    // Bus decode; byte lane 0 carries every register
    assign bus_idx = wb_req.adr[9:2];
    assign bus_hit = (wb_req.adr[11:10] == 2'h0);
    assign bus_fire = wb_req.cyc & wb_req.stb & ack_r;
    assign wb_ack_o = ack_r;

    // Ack one cycle after the request; dropped the cycle after
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_req.cyc & wb_req.stb & ~ack_r;
        end
    end

    // Read mux; unmapped addresses answer with zero
    always_comb begin
        rd_byte = 8'h00;
        if (bus_hit) begin
            case (bus_idx)
                `MLDA_IDX_CLK_SEL: rd_byte = clk_sel_r;
                `MLDA_IDX_LANE_EN: rd_byte = lane_en_r;
                `MLDA_IDX_MASK_LO: rd_byte = mask_lo_r;
                `MLDA_IDX_WORD_A_LO: rd_byte = word_a_lo_r;
                `MLDA_IDX_WORD_B_LO: rd_byte = word_b_lo_r;
                `MLDA_IDX_HIGH_BITS: rd_byte = high_bits_r;
                `MLDA_IDX_IRQ_EN: rd_byte = irq_en_r;
                `MLDA_IDX_GROUP_MODE: rd_byte = group_mode_r;
                `MLDA_IDX_FRAME_MODE: rd_byte = frame_mode_r;
                `MLDA_IDX_STATUS: rd_byte = status_w;
                `MLDA_IDX_IRQ_LAT: rd_byte = irq_lat_r;
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // Read data is sampled together with the ack
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req.cyc & wb_req.stb & ~ack_r) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end else begin
            wb_dat_o <= 32'h0000_0000;
        end
    end

    // Register writes take effect on the acked edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_sel_r <= `MLDA_RST_CLK_SEL;
            lane_en_r <= `MLDA_RST_LANE_EN;
            mask_lo_r <= `MLDA_RST_MASK_LO;
            word_a_lo_r <= `MLDA_RST_WORD_LO;
            word_b_lo_r <= `MLDA_RST_WORD_LO;
            high_bits_r <= `MLDA_RST_HIGH_BITS;
            irq_en_r <= `MLDA_RST_IRQ_EN;
            group_mode_r <= `MLDA_RST_GROUP_MODE;
            frame_mode_r <= `MLDA_RST_FRAME_MODE;
        end else if (bus_fire && wb_req.we && wb_req.sel[0] && bus_hit) begin
            case (bus_idx)
                `MLDA_IDX_CLK_SEL: clk_sel_r <= wb_req.dat[7:0];
                `MLDA_IDX_LANE_EN: lane_en_r <= wb_req.dat[7:0];
                `MLDA_IDX_MASK_LO: mask_lo_r <= wb_req.dat[7:0];
                `MLDA_IDX_WORD_A_LO: word_a_lo_r <= wb_req.dat[7:0];
                `MLDA_IDX_WORD_B_LO: word_b_lo_r <= wb_req.dat[7:0];
                `MLDA_IDX_HIGH_BITS: high_bits_r <= wb_req.dat[7:0];
                `MLDA_IDX_IRQ_EN: irq_en_r <= wb_req.dat[7:0];
                `MLDA_IDX_GROUP_MODE: group_mode_r <= wb_req.dat[7:0];
                `MLDA_IDX_FRAME_MODE: frame_mode_r <= wb_req.dat[7:0];
                default: ;
            endcase
        end
    end

    // Words and mask; bit 9 is the violation flag, bit 8 the control flag
    assign word_a = {high_bits_r[`MLDA_HB_A_MSB],
                     high_bits_r[`MLDA_HB_A_LSB], word_a_lo_r};
    assign word_b = {high_bits_r[`MLDA_HB_B_MSB],
                     high_bits_r[`MLDA_HB_B_LSB], word_b_lo_r};
    assign cmp_mask = {high_bits_r[`MLDA_HB_M_MSB],
                       high_bits_r[`MLDA_HB_M_LSB], mask_lo_r};

    // Status flags; the lanes 2/3 flag is idle in quad mode
    always_comb begin
        status_w = 8'h00;
        status_w[`MLDA_BIT_ALN01] = grp_locked[0];
        status_w[`MLDA_BIT_ALN23] = grp_locked[1] &
            ~group_mode_r[`MLDA_MODE_QUAD];
    end
    assign aligned_01 = status_w[`MLDA_BIT_ALN01];
    assign aligned_23 = status_w[`MLDA_BIT_ALN23];

    // Sticky latch: a read clears what it returned, but a flag still
    // high sets the bit again in the same edge, so set wins
    always_comb begin
        irq_lat_nxt = irq_lat_r;
        if (bus_fire && !wb_req.we && bus_hit &&
            bus_idx == `MLDA_IDX_IRQ_LAT) begin
            irq_lat_nxt = irq_lat_r & ~wb_dat_o[7:0];
        end
        irq_lat_nxt = (irq_lat_nxt | status_w) & irq_en_r;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_lat_r <= 8'h00;
        end else begin
            irq_lat_r <= irq_lat_nxt;
        end
    end

    assign status_irq = |irq_lat_r;

    // Resync reset: async assert, clocked release avoids partial wakeup
    assign aln_async_b = rst_b & ~align_resync;
    always_ff @(posedge ref_clk or negedge aln_async_b) begin
        if (!aln_async_b) begin
            aln_rst_sync_r <= 2'b00;
        end else begin
            aln_rst_sync_r <= {aln_rst_sync_r[0], 1'b1};
        end
    end
    assign aln_rst_b = aln_rst_sync_r[1];

    // Group membership per lane
    always_comb begin
        participate = lane_en_r[3:0] | {4{align_en}};
        lane_in_grp = 4'h0;
        lane_grp_idx = 4'h0;
        if (group_mode_r[`MLDA_MODE_QUAD]) begin
            lane_in_grp = 4'hF;
        end else begin
            if (group_mode_r[`MLDA_MODE_PAIR01]) begin
                lane_in_grp[1:0] = 2'h3;
            end
            if (group_mode_r[`MLDA_MODE_PAIR23]) begin
                lane_in_grp[3:2] = 2'h3;
                lane_grp_idx[3:2] = 2'h3;
            end
        end
        grp_mem[0] = lane_in_grp & participate & ~lane_grp_idx;
        grp_mem[1] = lane_in_grp & participate & lane_grp_idx;
    end

    // Per-lane capture, buffer and read-out
    for (genvar i = 0; i < 4; i++) begin : g_lane
        logic [2:0] clk_sync_r;
        logic clk_lvl_r;
        mlda_word_t d1_r;
        mlda_word_t d2_r;
        mlda_word_t d3_r;
        mlda_word_t buf_r [DEPTH];
        logic [AW-1:0] wr_ptr_r;
        logic [AW-1:0] rd_ptr_r;
        logic [AW:0] cnt_r;
        logic rd;
        logic wr;
        logic full;
        mlda_word_t head;

        // Three-stage sampling of lane clock and data
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                clk_sync_r <= 3'h0;
                d1_r <= '0;
                d2_r <= '0;
                d3_r <= '0;
            end else begin
                clk_sync_r <= {clk_sync_r[1:0], rx_lane_clk[i]};
                d1_r <= rx_lane_in[i];
                d2_r <= d1_r;
                d3_r <= d2_r;
            end
        end

        // Level accepted once stages two and three agree
        always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
                clk_lvl_r <= 1'b0;
            end else if (clk_sync_r[2] == clk_sync_r[1]) begin
                clk_lvl_r <= clk_sync_r[2];
            end
        end
        assign in_rise[i] = clk_sync_r[2] & clk_sync_r[1] & ~clk_lvl_r;

        // Output step on the selected recovered lane clock
        assign out_edge[i] = in_rise[clk_sel_r[2*i +: 2]];

        assign head = buf_r[rd_ptr_r];
        assign head_valid[i] = (cnt_r != '0);
        assign full = (cnt_r == FULL_CNT);
        assign wr = in_rise[i];
        assign overflow[i] = wr & full;

        // Marker test: the frame pulse in frame mode, else masked, against A or B
        assign head_mark[i] = frame_mode_r[0] ? head.frame :
            ((((head.word ^ word_a) & cmp_mask) == 10'h000) ||
             (((head.word ^ word_b) & cmp_mask) == 10'h000));

        // A full lane is forced on, so a stuck group cannot deadlock
        assign rd = out_edge[i] & head_valid[i] & (~stall[i] | full);

        // Buffer storage needs no reset; pointers guard it
        always_ff @(posedge ref_clk) begin
            if (wr && !full) begin
                buf_r[wr_ptr_r] <= d3_r;
            end
        end

        always_ff @(posedge ref_clk or negedge aln_rst_b) begin
            if (!aln_rst_b) begin
                wr_ptr_r <= '0;
                rd_ptr_r <= '0;
                cnt_r <= '0;
            end else begin
                if (wr && !full) begin
                    wr_ptr_r <= AW'((wr_ptr_r + 1'b1) % DEPTH);
                end
                if (rd) begin
                    rd_ptr_r <= AW'((rd_ptr_r + 1'b1) % DEPTH);
                end
                cnt_r <= cnt_r + (AW+1)'(wr && !full) - (AW+1)'(rd);
            end
        end

        // Lane output word and its one-cycle strobe
        always_ff @(posedge ref_clk or negedge aln_rst_b) begin
            if (!aln_rst_b) begin
                lane_out[i] <= '0;
                lane_out_valid[i] <= 1'b0;
            end else begin
                lane_out_valid[i] <= rd;
                if (rd) begin
                    lane_out[i] <= head;
                end
            end
        end

        // Hold a marker until every member lane shows one at its head
        assign stall[i] = lane_in_grp[i] & participate[i] & head_mark[i] &
            ~all_mark[lane_grp_idx[i]];
    end

    // Group alignment state
    for (genvar g = 0; g < 2; g++) begin : g_grp
        mlda_grp_state_t state_r;
        logic step;
        logic any_mark;

        assign all_mark[g] = (grp_mem[g] != 4'h0) &&
            (&(~grp_mem[g] | (head_mark & head_valid)));
        assign any_mark = |(grp_mem[g] & head_mark & head_valid);
        assign step = |(grp_mem[g] & out_edge);
        // Markers apart on one step, an overflow, or no members is loss
        assign grp_lost[g] = (step & any_mark & ~all_mark[g]) |
            (|(grp_mem[g] & overflow)) | (grp_mem[g] == 4'h0);

        always_ff @(posedge ref_clk or negedge aln_rst_b) begin
            if (!aln_rst_b) begin
                state_r <= MLDA_HUNT;
            end else begin
                case (state_r)
                    MLDA_HUNT: begin
                        if (step && all_mark[g]) begin
                            state_r <= MLDA_LOCKED;
                        end
                    end
                    MLDA_LOCKED: begin
                        if (grp_lost[g]) begin
                            state_r <= MLDA_HUNT;
                        end
                    end
                    default: state_r <= MLDA_HUNT;
                endcase
            end
        end
        assign grp_locked[g] = (state_r == MLDA_LOCKED);
    end

endmodule // mlda_aligner

/* hdl/mlda_defines.svh */
// Register map, field positions and reset values of the lane aligner
`ifndef MLDA_DEFINES_SVH
`define MLDA_DEFINES_SVH

// Register indices; byte address is four times the index
`define MLDA_IDX_CLK_SEL 8'h01
`define MLDA_IDX_LANE_EN 8'h04
`define MLDA_IDX_MASK_LO 8'h07
`define MLDA_IDX_WORD_A_LO 8'h08
`define MLDA_IDX_WORD_B_LO 8'h09
`define MLDA_IDX_HIGH_BITS 8'h0A
`define MLDA_IDX_IRQ_EN 8'h0C
`define MLDA_IDX_GROUP_MODE 8'h19
`define MLDA_IDX_FRAME_MODE 8'h1B
`define MLDA_IDX_STATUS 8'h82
`define MLDA_IDX_IRQ_LAT 8'h83

// Fields of the high-bits register (bus bit = 7 - printed bit)
`define MLDA_HB_A_MSB 3
`define MLDA_HB_A_LSB 2
`define MLDA_HB_B_MSB 1
`define MLDA_HB_B_LSB 0
`define MLDA_HB_M_MSB 5
`define MLDA_HB_M_LSB 4

// Group mode bits
`define MLDA_MODE_PAIR01 4
`define MLDA_MODE_PAIR23 5
`define MLDA_MODE_QUAD 6

// Status, enable and latch bit positions
`define MLDA_BIT_ALN01 5
`define MLDA_BIT_ALN23 4

// Reset values
`define MLDA_RST_CLK_SEL 8'h00
`define MLDA_RST_LANE_EN 8'h00
`define MLDA_RST_MASK_LO 8'hFF
`define MLDA_RST_WORD_LO 8'h7C
`define MLDA_RST_HIGH_BITS 8'h3F
`define MLDA_RST_IRQ_EN 8'h00
`define MLDA_RST_GROUP_MODE 8'h40
`define MLDA_RST_FRAME_MODE 8'h00

`endif

/* hdl/mlda_pkg.sv */
// Types shared by the lane aligner
package mlda_pkg;

    // One received lane word with its frame pulse
    typedef struct packed {
        logic frame;
        logic [9:0] word;
    } mlda_word_t;

    typedef enum logic {
        MLDA_HUNT,
        MLDA_LOCKED
    } mlda_grp_state_t;

    // Wishbone request as seen by the slave
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } mlda_wb_req_t;

endpackage

/* tb/mlda_aligner_properties.sv */
// Port-level assertions for the lane aligner
`timescale 1ns/100ps
`include "mlda_defines.svh"
module mlda_aligner_properties
    import mlda_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire mlda_wb_req_t wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic align_resync,
    input wire logic [3:0] lane_out_valid,
    input wire logic aligned_01,
    input wire logic aligned_23,
    input wire logic status_irq
);
    localparam logic [11:0] EN_A = {2'h0, `MLDA_IDX_IRQ_EN, 2'h0};
    localparam logic [11:0] MODE_A = {2'h0, `MLDA_IDX_GROUP_MODE, 2'h0};
    localparam logic [11:0] STA_A = {2'h0, `MLDA_IDX_STATUS, 2'h0};
    localparam logic [11:0] LAT_A = {2'h0, `MLDA_IDX_IRQ_LAT, 2'h0};
    logic [7:0] en_r;
    logic [7:0] mode_r;
    logic en_any;
    logic rd_lat;
    logic rd_sta;
    // Shadows of enable and mode; a write lands on its ack edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_r <= `MLDA_RST_IRQ_EN;
            mode_r <= `MLDA_RST_GROUP_MODE;
        end else if (wb_ack_o && wb_req.we && wb_req.sel[0]) begin
            if (wb_req.adr == EN_A)
                en_r <= wb_req.dat[7:0];
            if (wb_req.adr == MODE_A)
                mode_r <= wb_req.dat[7:0];
        end
    end
    // Read strobes of the two status slots
    assign en_any = |en_r[5:4];
    assign rd_lat = wb_ack_o && !wb_req.we && wb_req.adr == LAT_A;
    assign rd_sta = wb_ack_o && !wb_req.we && wb_req.adr == STA_A;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_answer: assert property
        ((wb_req.cyc && wb_req.stb && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_irq_set:
        assert property ((aligned_01 && en_r[5]) |-> ##[1:2] status_irq)
        else $error("enabled flag raised no request");
    a_irq_mask:
        assert property ((!en_any) [*3] |-> !status_irq)
        else $error("request with all enables off");
    a_quad_idle:
        assert property (mode_r[6] [*2] |-> !aligned_23)
        else $error("pair 2/3 flag in quad mode");
    a_resync_drop:
        assert property (align_resync |->
            !aligned_01 && !aligned_23 && lane_out_valid == 4'h0)
        else $error("flags or data alive in resync");
    a_read_clear:
        assert property ((rd_lat && !aligned_01 && !aligned_23) ##1
            (!aligned_01 && !aligned_23) |=> !status_irq)
        else $error("latch not cleared by read");
    a_status_read:
        assert property ((rd_sta && $stable(aligned_01) &&
            $stable(aligned_23)) |-> wb_dat_o[5:4] == {aligned_01, aligned_23})
        else $error("status read disagrees with flags");
    c_lock_01: cover property ($rose(aligned_01));
    c_lock_23: cover property ($rose(aligned_23));
    c_latch_rd: cover property (rd_lat && wb_dat_o[5]);
endmodule // mlda_aligner_properties

bind mlda_aligner mlda_aligner_properties #(.DEPTH(DEPTH))
    mlda_aligner_properties_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .align_resync(align_resync), .lane_out_valid(lane_out_valid),
    .aligned_01(aligned_01), .aligned_23(aligned_23),
    .status_irq(status_irq));

/* tb/mlda_lane_model.sv */
// Four skewed receive lanes carrying one shared word stream
`timescale 1ns/100ps
module mlda_lane_model
    import mlda_pkg::*;
(
    input wire logic [7:0] fill,
    input wire logic [9:0] mark,
    output logic [3:0] lane_clk = 4'h0,
    output mlda_word_t [3:0] lane_word = '0
);
    logic base;
    int step;
    mlda_word_t [3:0] hist;
    // 160 ns word clock; every lane is frequency locked to it
    initial begin
        base = 1'b0;
        step = 0;
        hist = '0;
        forever begin
            #80;
            base = 1'b1;
            // Marker with frame pulse every 16 words, payload between
            hist = {hist[2:0], (step % 16 == 0) ?
                {1'b1, mark} : {3'h0, fill}};
            step++;
            #80;
            base = 1'b0;
        end
    end
    // Lane g lags g words and 17g ns; data moves on its falling edge
    for (genvar g = 0; g < 4; g++) begin : g_lane
        always @(base) lane_clk[g] <= #(17 * g) base;
        always @(negedge lane_clk[g]) lane_word[g] <= hist[g];
    end
endmodule // mlda_lane_model

/* tb/test_mlda_aligner.sv */
// Self-checking bench for the lane aligner
`timescale 1ns/100ps
`include "mlda_defines.svh"
module test_mlda_aligner import mlda_pkg::*;;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    mlda_wb_req_t wb_req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] rx_lane_clk;
    mlda_word_t [3:0] rx_lane_in;
    logic align_resync = 1'b0;
    logic align_en = 1'b0;
    mlda_word_t [3:0] lane_out;
    logic [3:0] lane_out_valid;
    logic aligned_01;
    logic aligned_23;
    logic status_irq;
    logic [7:0] fill_r = 8'h00;
    logic [9:0] mark_r = 10'h17C;
    logic quad_on = 1'b1;
    int seed = 1101;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] exp_q[$];

    mlda_aligner #(.DEPTH(16)) mlda_aligner_i (.ref_clk(ref_clk),
        .rst_b(rst_b), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_lane_clk(rx_lane_clk),
        .rx_lane_in(rx_lane_in), .align_en(align_en),
        .align_resync(align_resync), .lane_out(lane_out),
        .lane_out_valid(lane_out_valid), .aligned_01(aligned_01),
        .aligned_23(aligned_23), .status_irq(status_irq));
    mlda_lane_model mlda_lane_model_i (.fill(fill_r), .mark(mark_r),
        .lane_clk(rx_lane_clk), .lane_word(rx_lane_in));

    initial forever #4 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb_cyc(input logic we, input logic [7:0] idx,
        input logic [7:0] d);
        @(posedge ref_clk);
        wb_req <= '{1'b1, 1'b1, we, {2'h0, idx, 2'h0}, 4'hF, {24'h0, d}};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        wb_req <= '0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb_cyc(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        wb_cyc(1'b0, idx, 8'h00);
    endtask

    task automatic wait_aln(input logic pair);
        int n;
        n = 0;
        while ((pair ? aligned_23 : aligned_01) !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        chk("lock", 32'h1, 32'(pair ? aligned_23 : aligned_01));
    endtask

    // Random payload each cycle; the cycle count cuts a hang short
    always @(posedge ref_clk) begin
        fill_r <= 8'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // Read answers and aligned lane words are judged as they appear
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && !wb_req.we) begin
            if (exp_q.size() == 0)
                chk("spare read", 32'h1, 32'h0);
            else
                chk("read data", exp_q.pop_front(), wb_dat_o);
        end
        if (quad_on && aligned_01 === 1'b1 && lane_out_valid === 4'hF)
            for (int g = 1; g < 4; g++)
                chk("lane word", 32'(lane_out[0]), 32'(lane_out[g]));
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // Reset values, an unmapped slot, a read-only slot
        rd(`MLDA_IDX_MASK_LO, `MLDA_RST_MASK_LO);
        rd(`MLDA_IDX_HIGH_BITS, `MLDA_RST_HIGH_BITS);
        rd(`MLDA_IDX_GROUP_MODE, `MLDA_RST_GROUP_MODE);
        rd(8'h30, 8'h00);
        wr(`MLDA_IDX_STATUS, 8'hFF);
        rd(`MLDA_IDX_STATUS, 8'h00);
        // Word A 0x17C, word B 0x1BC, all ten bits compared
        wr(`MLDA_IDX_WORD_A_LO, 8'h7C);
        wr(`MLDA_IDX_WORD_B_LO, 8'hBC);
        wr(`MLDA_IDX_HIGH_BITS, 8'h35);
        rd(`MLDA_IDX_HIGH_BITS, 8'h35);
        wr(`MLDA_IDX_LANE_EN, 8'h0F);
        wait_aln(1'b0);
        rd(`MLDA_IDX_STATUS, 8'h20);
        rd(`MLDA_IDX_IRQ_LAT, 8'h00);
        chk("irq masked", 32'h0, 32'(status_irq));
        wr(`MLDA_IDX_IRQ_EN, 8'h30);
        repeat (3) @(posedge ref_clk);
        chk("irq raised", 32'h1, 32'(status_irq));
        rd(`MLDA_IDX_IRQ_LAT, 8'h20);
        rd(`MLDA_IDX_IRQ_LAT, 8'h20);
        // Resync drops the flag; the latch must outlive it
        align_resync <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("aligned", 32'h0, 32'(aligned_01));
        rd(`MLDA_IDX_IRQ_LAT, 8'h20);
        rd(`MLDA_IDX_IRQ_LAT, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 32'h0, 32'(status_irq));
        // Marker hits only word B, and only with bit 8 masked off
        mark_r <= 10'h0BC;
        wr(`MLDA_IDX_HIGH_BITS, 8'h05);
        repeat (400) @(posedge ref_clk);
        align_resync <= 1'b0;
        wait_aln(1'b0);
        // Two independent pairs
        quad_on <= 1'b0;
        align_resync <= 1'b1;
        wr(`MLDA_IDX_GROUP_MODE, 8'h30);
        align_resync <= 1'b0;
        wait_aln(1'b1);
        wait_aln(1'b0);
        rd(`MLDA_IDX_STATUS, 8'h30);
        rd(`MLDA_IDX_IRQ_LAT, 8'h30);
        // One marker only, pin enable, lane 1 clock, frame pulses
        wr(`MLDA_IDX_WORD_B_LO, 8'h7C);
        wr(`MLDA_IDX_LANE_EN, 8'h00);
        align_en <= 1'b1;
        wr(`MLDA_IDX_CLK_SEL, 8'h55);
        wr(`MLDA_IDX_FRAME_MODE, 8'h01);
        mark_r <= 10'h000;
        align_resync <= 1'b1;
        repeat (2) @(posedge ref_clk);
        align_resync <= 1'b0;
        wait_aln(1'b0);
        wait_aln(1'b1);
        rd(`MLDA_IDX_STATUS, 8'h30);
        report_and_stop();
    end
endmodule // test_mlda_aligner
